// File: rtl/ubp_pin_functions.sv
// Pin-level host port, interrupt, request-to-send and programmable I/O logic of the bridge.
`timescale 1ns/1ns
module ubp_pin_functions (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       host_sel,
    input  wire logic                       select_or_addr_bit0,
    input  wire logic                       serial_in_or_addr_bit1,
    input  wire logic                       host_clk,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic                       i2c_sda_drive_low,
    output logic                            serial_out,
    output logic                            serial_out_oe,
    input  wire logic [ubp_pkg::BYTE_W-1:0] spi_tx_byte,
    output logic [ubp_pkg::BYTE_W-1:0]      spi_rx_byte,
    output logic                            spi_rx_valid,
    output logic                            i2c_mode,
    output logic [1:0]                      i2c_base_addr,
    output logic                            scl_level,
    output logic                            sda_level,
    output logic                            irq_n_out,
    output logic                            irq_n_oe,
    input  wire logic [ubp_pkg::EVT_W-1:0]  interrupt_enable_reg,
    input  wire logic                       rx_error_evt,
    input  wire logic                       rx_data_evt,
    input  wire logic                       tx_room_evt,
    input  wire logic [ubp_pkg::EVT_W-1:0]  int_clear,
    output logic [ubp_pkg::EVT_W-1:0]       int_pending,
    input  wire logic [ubp_pkg::REG_W-1:0]  modem_control_reg,
    input  wire logic [ubp_pkg::REG_W-1:0]  enhanced_feature_reg,
    input  wire logic                       rx_fifo_has_room,
    output logic                            rts_n,
    output logic                            rts_flow_active,
    input  wire logic [ubp_pkg::REG_W-1:0]  io_control_reg,
    input  wire logic [ubp_pkg::IO_W-1:0]   prog_io_dir,
    input  wire logic [ubp_pkg::IO_W-1:0]   prog_io_value,
    input  wire logic                       terminal_ready_value,
    input  wire logic [ubp_pkg::IO_W-1:0]   prog_io_in,
    output logic [ubp_pkg::IO_W-1:0]        prog_io_out,
    output logic [ubp_pkg::IO_W-1:0]        prog_io_oe,
    output logic [ubp_pkg::IO_W-1:0]        prog_io_level,
    output logic [3:0]                      modem_status
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    logic [ubp_pkg::SYNC_W-1:0] sync_a;
    logic [ubp_pkg::SYNC_W-1:0] sync_b;
    logic [ubp_pkg::SYNC_W-1:0] pins;

    // Every external pin passes two flip-flops; only sync_b is read by logic.
    assign pins = {prog_io_in, sda_in, host_clk, serial_in_or_addr_bit1, select_or_addr_bit0, host_sel};

    // The stages are not reset, so the strap is already settled when reset ends.
    always_ff @(posedge ref_clk) begin
        sync_a <= pins;
        sync_b <= sync_a;
    end

    // ------------------------------------------------------------------
    // Strap capture and shared pin decoding
    // ------------------------------------------------------------------

    logic       strap_taken;
    logic       next_strap_taken;
    logic       next_i2c_mode;
    logic [1:0] next_i2c_base_addr;
    logic       hclk_prev;
    logic       cs_active;
    logic       hclk_rise;
    logic       hclk_fall;
    logic [ubp_pkg::IO_W-1:0] io_sync;
    logic [ubp_pkg::IO_W-1:0] io_prev;

    assign io_sync = sync_b[ubp_pkg::S_IO_LO +: ubp_pkg::IO_W];
    assign cs_active = !i2c_mode && strap_taken && !sync_b[ubp_pkg::S_A0];
    assign hclk_rise = sync_b[ubp_pkg::S_HCLK] && !hclk_prev;
    assign hclk_fall = !sync_b[ubp_pkg::S_HCLK] && hclk_prev;
    assign scl_level = sync_b[ubp_pkg::S_HCLK];
    assign sda_level = sync_b[ubp_pkg::S_SDA];

    // The strap is caught once, on the first cycle after reset release.
    always_comb begin
        next_strap_taken   = 1'b1;
        next_i2c_mode      = i2c_mode;
        next_i2c_base_addr = i2c_base_addr;
        if (!strap_taken) begin
            next_i2c_mode = sync_b[ubp_pkg::S_HOST_SEL];
        end
        if (i2c_mode && strap_taken) begin
            next_i2c_base_addr = {sync_b[ubp_pkg::S_A1], sync_b[ubp_pkg::S_A0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_taken   <= 1'b0;
            i2c_mode      <= 1'b0;
            i2c_base_addr <= 2'h0;
            hclk_prev     <= sync_b[ubp_pkg::S_HCLK];  // No false clock edge after reset.
            io_prev       <= io_sync;                  // No false pin change after reset.
        end else begin
            strap_taken   <= next_strap_taken;
            i2c_mode      <= next_i2c_mode;
            i2c_base_addr <= next_i2c_base_addr;
            hclk_prev     <= sync_b[ubp_pkg::S_HCLK];
            io_prev       <= io_sync;
        end
    end

    // ------------------------------------------------------------------
    // SPI mode 0 shifter
    // ------------------------------------------------------------------

    logic [2:0]                 bit_cnt;
    logic [2:0]                 next_bit_cnt;
    logic [ubp_pkg::BYTE_W-1:0] rx_shift;
    logic [ubp_pkg::BYTE_W-1:0] next_rx_shift;
    logic [ubp_pkg::BYTE_W-1:0] tx_shift;
    logic [ubp_pkg::BYTE_W-1:0] next_tx_shift;
    logic [ubp_pkg::BYTE_W-1:0] next_spi_rx_byte;
    logic                       next_spi_rx_valid;
    logic                       cs_prev;

    // Data is taken on rising clock edges and shifted out on falling ones.
    always_comb begin
        next_bit_cnt      = bit_cnt;
        next_rx_shift     = rx_shift;
        next_tx_shift     = tx_shift;
        next_spi_rx_byte  = spi_rx_byte;
        next_spi_rx_valid = 1'b0;
        if (!cs_active) begin
            next_bit_cnt = ubp_pkg::BIT_FIRST;
        end else if (!cs_prev) begin
            next_tx_shift = spi_tx_byte;
        end else if (hclk_rise) begin
            next_rx_shift = {rx_shift[ubp_pkg::BYTE_W-2:0], sync_b[ubp_pkg::S_A1]};
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == ubp_pkg::BIT_LAST) begin
                next_spi_rx_byte  = {rx_shift[ubp_pkg::BYTE_W-2:0], sync_b[ubp_pkg::S_A1]};
                next_spi_rx_valid = 1'b1;
            end
        end else if (hclk_fall) begin
            if (bit_cnt == ubp_pkg::BIT_FIRST) begin
                next_tx_shift = spi_tx_byte;
            end else begin
                next_tx_shift = {tx_shift[ubp_pkg::BYTE_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_cnt      <= ubp_pkg::BIT_FIRST;
            rx_shift     <= ubp_pkg::BYTE_RST;
            tx_shift     <= ubp_pkg::BYTE_RST;
            spi_rx_byte  <= ubp_pkg::BYTE_RST;
            spi_rx_valid <= 1'b0;
            cs_prev      <= 1'b0;
        end else begin
            bit_cnt      <= next_bit_cnt;
            rx_shift     <= next_rx_shift;
            tx_shift     <= next_tx_shift;
            spi_rx_byte  <= next_spi_rx_byte;
            spi_rx_valid <= next_spi_rx_valid;
            cs_prev      <= cs_active;
        end
    end

    assign serial_out    = tx_shift[ubp_pkg::BYTE_W-1];
    assign serial_out_oe = cs_active;
    assign sda_out       = 1'b0;
    assign sda_oe        = i2c_mode && strap_taken && i2c_sda_drive_low;

    // ------------------------------------------------------------------
    // Interrupt sources and open-drain request line
    // ------------------------------------------------------------------

    logic                      modem_sel;
    logic [ubp_pkg::EVT_W-1:0] evt;
    logic [ubp_pkg::EVT_W-1:0] next_int_pending;
    logic                      next_irq;
    logic [ubp_pkg::IO_W-1:0]  io_changed;
    logic [ubp_pkg::IO_W-1:0]  modem_mask;

    assign modem_sel  = io_control_reg[ubp_pkg::IOC_MODEM_BIT];
    assign modem_mask = modem_sel ? {{(ubp_pkg::IO_W - ubp_pkg::MODEM_LO){1'b1}}, {ubp_pkg::MODEM_LO{1'b0}}}
                                  : ubp_pkg::IO_RST;
    assign io_changed = (io_sync ^ io_prev) & ~prog_io_dir;

    // Sticky flags; a new event in the clearing cycle keeps its flag set.
    always_comb begin
        evt                     = ubp_pkg::EVT_RST;
        evt[ubp_pkg::EVT_IO]     = |(io_changed & ~modem_mask);
        evt[ubp_pkg::EVT_RXERR]  = rx_error_evt;
        evt[ubp_pkg::EVT_RXDATA] = rx_data_evt;
        evt[ubp_pkg::EVT_TXROOM] = tx_room_evt;
        evt[ubp_pkg::EVT_MODEM]  = |((io_sync ^ io_prev) & modem_mask);
        next_int_pending = (int_pending & ~int_clear) | evt;
        next_irq = |(int_pending & interrupt_enable_reg);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_pending <= ubp_pkg::EVT_RST;
            irq_n_oe    <= 1'b0;
        end else begin
            int_pending <= next_int_pending;
            irq_n_oe    <= next_irq;
        end
    end

    assign irq_n_out = 1'b0;

    // ------------------------------------------------------------------
    // Request-to-send
    // ------------------------------------------------------------------

    logic next_rts_n;
    logic auto_rts;

    assign auto_rts = enhanced_feature_reg[ubp_pkg::EFR_ARTS_BIT];

    always_comb begin
        if (auto_rts) begin
            next_rts_n = !rx_fifo_has_room;
        end else begin
            next_rts_n = !modem_control_reg[ubp_pkg::MCR_RTS_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rts_n           <= 1'b1;
            rts_flow_active <= 1'b0;
        end else begin
            rts_n           <= next_rts_n;
            rts_flow_active <= auto_rts;
        end
    end

    // ------------------------------------------------------------------
    // Programmable I/O and modem lines
    // ------------------------------------------------------------------

    logic [ubp_pkg::IO_W-1:0] next_prog_io_out;
    logic [ubp_pkg::IO_W-1:0] next_prog_io_oe;

    always_comb begin
        next_prog_io_out = prog_io_value;
        next_prog_io_oe  = prog_io_dir;
        if (modem_sel) begin
            next_prog_io_oe[ubp_pkg::IO_DSR]  = 1'b0;
            next_prog_io_oe[ubp_pkg::IO_CD]   = 1'b0;
            next_prog_io_oe[ubp_pkg::IO_RI]   = 1'b0;
            next_prog_io_oe[ubp_pkg::IO_DTR]  = 1'b1;
            next_prog_io_out[ubp_pkg::IO_DTR] = terminal_ready_value;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prog_io_out <= ubp_pkg::IO_RST;
            prog_io_oe  <= ubp_pkg::IO_RST;
        end else begin
            prog_io_out <= next_prog_io_out;
            prog_io_oe  <= next_prog_io_oe;
        end
    end

    assign prog_io_level = io_sync;
    assign modem_status  = io_sync[ubp_pkg::MODEM_LO +: 4];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    AST_RTS_RESET: assert property (@(posedge ref_clk) rst |=> rts_n)
        else $error("Request-to-send not high after reset.");
    AST_RTS_MANUAL: assert property (@(posedge ref_clk) disable iff (rst)
        (!auto_rts && modem_control_reg[ubp_pkg::MCR_RTS_BIT]) |=> !rts_n)
        else $error("Manual request-to-send did not drive low.");
    AST_RTS_AUTO: assert property (@(posedge ref_clk) disable iff (rst)
        auto_rts |=> (rts_n == !$past(rx_fifo_has_room)))
        else $error("Automatic request-to-send ignores fifo room.");
    AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        irq_n_oe |-> |($past(int_pending) & $past(interrupt_enable_reg)))
        else $error("Interrupt asserted with no enabled pending source.");
    AST_PEND_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        rx_data_evt |=> int_pending[ubp_pkg::EVT_RXDATA])
        else $error("Receive data event lost.");
    AST_SO_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
        sync_b[ubp_pkg::S_A0] |-> !serial_out_oe)
        else $error("Data out driven while deselected.");
    AST_SDA_I2C: assert property (@(posedge ref_clk) disable iff (rst)
        sda_oe |-> i2c_mode && !sda_out)
        else $error("Data pin driven outside I2C mode.");
    AST_SPI_BYTE: assert property (@(posedge ref_clk) disable iff (rst)
        spi_rx_valid |-> ($past(bit_cnt) == ubp_pkg::BIT_LAST) && !i2c_mode)
        else $error("SPI byte completed at wrong bit count.");
    AST_MODEM_DIR: assert property (@(posedge ref_clk) disable iff (rst)
        modem_sel ##1 modem_sel |-> prog_io_oe[ubp_pkg::IO_DTR] && !prog_io_oe[ubp_pkg::IO_DSR])
        else $error("Modem line directions wrong.");

endmodule : ubp_pin_functions

// File: rtl/ubp_pkg.sv
// Shared constants for the serial-bus bridge pin-function block.
package ubp_pkg;
    // Synchronised pin vector layout.
    localparam int SYNC_W     = 13;
    localparam int S_HOST_SEL = 0;
    localparam int S_A0       = 1;
    localparam int S_A1       = 2;
    localparam int S_HCLK     = 3;
    localparam int S_SDA      = 4;
    localparam int S_IO_LO    = 5;
    // Programmable I/O pins and modem line positions.
    localparam int IO_W       = 8;
    localparam int IO_DSR     = 4;
    localparam int IO_DTR     = 5;
    localparam int IO_CD      = 6;
    localparam int IO_RI      = 7;
    localparam int MODEM_LO   = 4;
    // Register bit positions.
    localparam int REG_W          = 8;
    localparam int MCR_RTS_BIT    = 1;
    localparam int EFR_ARTS_BIT   = 6;
    localparam int IOC_MODEM_BIT  = 1;
    // Interrupt source positions.
    localparam int EVT_W      = 5;
    localparam int EVT_IO     = 0;
    localparam int EVT_RXERR  = 1;
    localparam int EVT_RXDATA = 2;
    localparam int EVT_TXROOM = 3;
    localparam int EVT_MODEM  = 4;
    // SPI byte framing.
    localparam int BYTE_W     = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // Reset values.
    localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0007;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [EVT_W-1:0]  EVT_RST  = 5'h00;
    localparam logic [IO_W-1:0]   IO_RST   = 8'h00;
endpackage : ubp_pkg

// File: tb/ubp_host_model.sv
// Host-side serial master model that frames bytes onto the shared pins.
`timescale 1ns/1ns
module ubp_host_model (
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    // Idle lines: deselected, clock standing still low.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // host clock and data
    // Data is set while the clock is low and taken on the rise, MSB first.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #24 sclk = 1'b1;
            rx[i] = miso;
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        mosi = ~mosi;  // A released line must not show the last bit.
        #48;
    endtask : xfer
endmodule : ubp_host_model

// File: tb/testbench.sv
// Self-checking bench for the bridge pin-function block.
`timescale 1ns/1ns
module testbench;
    logic       ref_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       host_sel  = 1'b0;
    logic       a0        = 1'b0;
    logic       a1        = 1'b0;
    logic       drive_low = 1'b0;
    logic       tr_val    = 1'b0;
    logic       room      = 1'b0;
    logic [2:0] evt       = 3'h0;
    logic [4:0] int_en    = 5'h00;
    logic [4:0] clr       = 5'h00;
    logic [7:0] modem_ctl = 8'h00;
    logic [7:0] feat      = 8'h00;
    logic [7:0] io_ctl    = 8'h00;
    logic [7:0] dir       = 8'h00;
    logic [7:0] val       = 8'h00;
    logic [7:0] pins      = 8'h00;
    logic [7:0] tx        = 8'h00;
    wire        h_cs, h_sclk, h_mosi, sdo, sdo_oe, sda_oe, i2c_mode, rts_n, irq_oe, sda_lvl;
    wire        sda_o, scl, rx_vld, irq_out, rts_flow;
    int         n_valid   = 0;
    wire  [1:0] base;
    wire  [3:0] mstat;
    wire  [4:0] pend;
    wire  [7:0] rxb, io_out, io_oe, io_lvl;
    int         err_total = 0;
    int         n_tests   = 0;

    // Shared pins are steered by the strap; the data line has a pull-up in the bus mode.
    wire sel_pin = host_sel ? a0 : h_cs;
    wire si_pin  = host_sel ? a1 : h_mosi;
    wire sda_pin = host_sel ? ~sda_oe : 1'b0;

    always #2 ref_clk = ~ref_clk;

    ubp_host_model u_ubp_host_model (.cs_n(h_cs), .sclk(h_sclk), .mosi(h_mosi), .miso(sdo));

    ubp_pin_functions u_ubp_pin_functions (
        .ref_clk(ref_clk), .rst(rst), .host_sel(host_sel), .select_or_addr_bit0(sel_pin),
        .serial_in_or_addr_bit1(si_pin), .host_clk(h_sclk), .sda_in(sda_pin), .sda_out(sda_o),
        .sda_oe(sda_oe), .i2c_sda_drive_low(drive_low), .serial_out(sdo), .serial_out_oe(sdo_oe),
        .spi_tx_byte(tx), .spi_rx_byte(rxb), .spi_rx_valid(rx_vld), .i2c_mode(i2c_mode), .i2c_base_addr(base),
        .scl_level(scl), .sda_level(sda_lvl), .irq_n_out(irq_out), .irq_n_oe(irq_oe), .interrupt_enable_reg(int_en),
        .rx_error_evt(evt[0]), .rx_data_evt(evt[1]), .tx_room_evt(evt[2]), .int_clear(clr),
        .int_pending(pend), .modem_control_reg(modem_ctl), .enhanced_feature_reg(feat),
        .rx_fifo_has_room(room), .rts_n(rts_n), .rts_flow_active(rts_flow), .io_control_reg(io_ctl),
        .prog_io_dir(dir), .prog_io_value(val), .terminal_ready_value(tr_val), .prog_io_in(pins),
        .prog_io_out(io_out), .prog_io_oe(io_oe), .prog_io_level(io_lvl), .modem_status(mstat));

    // Counts received-byte pulses away from the edge that launches them.
    always @(negedge ref_clk) begin
        if (rx_vld === 1'b1)
            n_valid++;
    end

    // Waits n rising edges, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_vec

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Idle levels after the power-up reset.
    task automatic t_reset;
        chk_bit("rts_n", 1'b1, rts_n);
        chk_bit("irq_n_oe", 1'b0, irq_oe);
        chk_bit("i2c_mode", 1'b0, i2c_mode);
        chk_bit("serial_out_oe", 1'b0, sdo_oe);
        chk_vec("prog_io_oe", 8'h00, io_oe);
    endtask : t_reset

    // Manual request-to-send, then automatic mode overriding it.
    task automatic t_rts;
        modem_ctl = 8'h02;
        tick(2);
        chk_bit("rts_n manual on", 1'b0, rts_n);
        modem_ctl = 8'h00;
        tick(2);
        chk_bit("rts_n manual off", 1'b1, rts_n);
        feat = 8'h40;
        modem_ctl = 8'h02;
        room = 1'b1;
        tick(2);
        chk_bit("rts_n auto room", 1'b0, rts_n);
        chk_bit("rts_flow_active on", 1'b1, rts_flow);
        room = 1'b0;
        tick(2);
        chk_bit("rts_n auto full", 1'b1, rts_n);
        feat = 8'h00;
        tick(2);
        chk_bit("rts_n manual back", 1'b0, rts_n);
        chk_bit("rts_flow_active off", 1'b0, rts_flow);
        modem_ctl = 8'h00;
    endtask : t_rts

    // Direction, value and modem-line function of the programmable pins.
    task automatic t_io;
        dir = 8'h3C;
        val = 8'hA5;
        tick(2);
        chk_vec("prog_io_oe", 8'h3C, io_oe);
        chk_vec("prog_io_out", 8'h24, io_out & 8'h3C);
        io_ctl = 8'h02;
        dir = 8'hFF;
        tr_val = 1'b0;
        tick(2);
        chk_vec("modem prog_io_oe", 8'h2F, io_oe);
        chk_vec("modem prog_io_out", 8'h05, io_out & 8'h2F);
        pins = 8'h96;
        tick(4);
        chk_vec("prog_io_level", 8'h96, io_lvl);
        chk_vec("modem_status", 8'h09, {4'h0, mstat});
        tr_val = 1'b1;
        tick(2);
        chk_vec("modem terminal ready", 8'h25, io_out & 8'h2F);
        tr_val = 1'b0;
        dir = 8'h00;
        io_ctl = 8'h00;
    endtask : t_io

    // Two framed bytes each way; the data-out pin is released between frames.
    task automatic t_spi;
        logic [7:0] got;
        logic [7:0] sent;
        drive_low = 1'b1;
        for (int k = 0; k < 2; k++) begin
            tx = (k == 0) ? 8'h3C : 8'hC3;
            sent = (k == 0) ? 8'hA5 : 8'h5A;
            fork
                u_ubp_host_model.xfer(sent, got);
                begin
                    tick(12);
                    chk_bit("serial_out_oe in frame", 1'b1, sdo_oe);
                    chk_bit("scl_level in frame", 1'b1, scl);
                end
            join
            tick(1);
            chk_vec("serial_out byte", tx, got);
            chk_vec("spi_rx_byte", sent, rxb);
            chk_vec("spi_rx_valid pulses", 8'(k + 1), 8'(n_valid));
            chk_bit("serial_out_oe idle", 1'b0, sdo_oe);
            chk_bit("sda_oe spi", 1'b0, sda_oe);
        end
        drive_low = 1'b0;
    endtask : t_spi

    // Every interrupt source: pending without enable, pin pulled once enabled, cleared.
    task automatic t_irq;
        for (int i = 0; i < 5; i++) begin
            io_ctl = (i == 4) ? 8'h02 : 8'h00;
            tick(6);
            clr = 5'h1F;
            tick(1);
            clr = 5'h00;
            if (i == 0)
                pins[0] = ~pins[0];
            else if (i == 4)
                pins[4] = ~pins[4];
            else
                evt[i-1] = 1'b1;
            tick(1);
            evt = 3'h0;
            tick(6);
            chk_vec("int_pending", {3'h0, 5'(5'h01 << i)}, {3'h0, pend});
            chk_bit("irq_n_oe masked", 1'b0, irq_oe);
            int_en = 5'(5'h01 << i);
            tick(3);
            chk_bit("irq_n_oe enabled", 1'b1, irq_oe);
            chk_bit("irq_n_out", 1'b0, irq_out);
            clr = 5'(5'h01 << i);
            tick(1);
            clr = 5'h00;
            int_en = 5'h00;
            tick(3);
            chk_vec("int_pending cleared", 8'h00, {3'h0, pend});
            chk_bit("irq_n_oe cleared", 1'b0, irq_oe);
        end
        evt[1] = 1'b1;
        clr = 5'h1F;
        tick(1);
        evt = 3'h0;
        chk_vec("int_pending set wins", 8'h04, {3'h0, pend});
        tick(1);
        clr = 5'h00;
        io_ctl = 8'h00;
    endtask : t_irq

    // Mid-run reset into the bus mode with the manual request-to-send bit set.
    task automatic t_i2c;
        modem_ctl = 8'h02;
        a1 = 1'b1;
        host_sel = 1'b1;
        tick(2);
        rst = 1'b1;
        tick(1);
        chk_bit("rts_n in reset", 1'b1, rts_n);
        tick(3);
        rst = 1'b0;
        tick(4);
        chk_bit("i2c_mode", 1'b1, i2c_mode);
        chk_vec("i2c_base_addr", 8'h02, {6'h00, base});
        chk_bit("rts_n after reset", 1'b0, rts_n);
        chk_bit("serial_out_oe i2c", 1'b0, sdo_oe);
        drive_low = 1'b1;
        tick(1);
        chk_bit("sda_oe pull", 1'b1, sda_oe);
        chk_bit("sda_out", 1'b0, sda_o);
        tick(3);
        chk_bit("sda_level", 1'b0, sda_lvl);
        drive_low = 1'b0;
        a0 = 1'b1;
        tick(4);
        chk_bit("sda_oe release", 1'b0, sda_oe);
        chk_vec("i2c_base_addr", 8'h03, {6'h00, base});
    endtask : t_i2c

    // Main sequence.
    initial begin
        tick(2);
        rst = 1'b0;
        tick(3);
        t_reset;
        t_rts;
        t_io;
        t_spi;
        t_irq;
        t_i2c;
        close_out;
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #60000;
        err_total++;
        close_out;
    end
endmodule : testbench
